//--- rtl/cirsl_pkg.sv
// Package: register map, field positions and reset values of the interrupt block
package cirsl_pkg;
  localparam int unsigned DATA_W      = 64;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned LEVEL_W     = 5;
  localparam int unsigned NUM_LEVELS  = 32;
  // Register indices on the plain register port
  localparam logic [3:0] REG_THRESHOLD = 4'h0;
  localparam logic [3:0] REG_TRAP_REQ  = 4'h1;
  localparam logic [3:0] REG_TRAP_EN   = 4'h2;
  localparam logic [3:0] REG_SOFT_REQ  = 4'h3;
  localparam logic [3:0] REG_CLEAR     = 4'h4;
  localparam logic [3:0] REG_SUMMARY   = 4'h5;
  localparam logic [3:0] REG_SER_XMIT  = 4'h6;
  localparam logic [3:0] REG_SER_RCV   = 4'h7;
  localparam logic [3:0] REG_CTRL_STAT = 4'h8;
  localparam logic [3:0] REG_CUR_MODE  = 4'h9;
  localparam logic [3:0] REG_LEVEL_ID  = 4'hA;
  // Field positions
  localparam int unsigned THR_LSB     = 0;
  localparam int unsigned TRAP_LSB    = 0;
  localparam int unsigned TRAP_W      = 4;
  localparam int unsigned SOFT_LSB    = 4;
  localparam int unsigned SOFT_W      = 15;
  localparam int unsigned SUM_TRAP    = 19;
  localparam int unsigned SUM_PIN_LSB = 20;
  localparam int unsigned PIN_W       = 4;
  localparam int unsigned CTR_LSB     = 27;
  localparam int unsigned CTR_W       = 3;
  localparam int unsigned SUM_PWR     = 30;
  localparam int unsigned SUM_MCHK    = 31;
  localparam int unsigned CRD_BIT     = 32;
  localparam int unsigned SER_BIT     = 33;
  localparam int unsigned SUM_HALT    = 34;
  localparam int unsigned MASK_LSB    = 20;
  localparam int unsigned XMIT_BIT    = 7;
  localparam int unsigned RCV_BIT     = 6;
  localparam int unsigned MODE_LSB    = 3;
  localparam int unsigned MODE_W      = 2;
  // Target levels
  localparam logic [4:0] LVL_CTR      = 5'h1D;
  localparam logic [4:0] LVL_PWR      = 5'h1E;
  localparam logic [4:0] LVL_MCHK     = 5'h1F;
  localparam logic [4:0] LVL_CRD      = 5'h1F;
  localparam logic [4:0] LVL_PIN0     = 5'h14;
  localparam logic [4:0] LVL_SER_DEF  = 5'h14;
  localparam logic [4:0] LVL_TRAP_DEF = 5'h02;
  // Reset values
  localparam logic [4:0] THR_RST      = 5'h00;
  localparam logic       XMIT_RST     = 1'b1;
  localparam logic       SER_IDLE     = 1'b1;
  localparam logic [1:0] MODE_RST     = 2'h0;
endpackage : cirsl_pkg

//--- rtl/cirsl_top.sv
// Interrupt priority, request and summary logic with software-timed serial line
// Function
// - Interrupt taken when level exceeds threshold
// - Level identifier shows highest pending level
// - Halt has no level; summary bit 34
// - Trap needs request, enable, privileged enough mode
// - Trap request bits 3:0, others read zero
// - Soft request bits 18:4 give levels 1-15
// - Clear register write-one clears latched requests
// - Summary 3:0 is trap request AND enable
// - Summary 18:4 shows soft requests, resets zero
// - Summary 19 set for any active trap
// - Summary reports masked pins too; bits 20-23 mirror pins
// - Summary 27-29 counter requests, level 29
// - Summary 30 power fail, 31 machine check
// - Summary 32 corrected error, 33 serial line
// - Transmit bit 7, reset one, drives clock pin
// - Clock pin shared with ROM load outside debug
// - Receive bit 6 shows data pin level
// - Data pin transitions request when enable set
// - Control mask bits block matching pin requests
// - Control bits 33, 32 enable serial, corrected
module cirsl_top
  import cirsl_pkg::*;
#(
  parameter logic [4:0] LVL_TRAP = LVL_TRAP_DEF,
  parameter logic [4:0] LVL_SER  = LVL_SER_DEF
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_we,
  input  wire logic              reg_re,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic [PIN_W-1:0]  irq_pin,
  input  wire logic              power_fail_pin,
  input  wire logic              machine_check_pin,
  input  wire logic              halt_pin,
  input  wire logic [CTR_W-1:0]  counter_event,
  input  wire logic              corrected_read_event,
  input  wire logic              srom_data_pin,
  input  wire logic              rom_load_active,
  input  wire logic              rom_load_clk,
  input  wire logic              debug_mode,
  output logic                   srom_clk_pin,
  output logic      [4:0]        pending_level_identifier,
  output logic                   interrupt_take,
  output logic                   halt_pending
);

  // Highest set index of a level request vector
  // Level zero means nothing pending, so bit 0 is never a request
  function automatic logic [4:0] cirsl_top_level(input logic [NUM_LEVELS-1:0] req);
    logic [4:0] lvl;
    lvl = 5'h00;
    for (int i = 1; i < NUM_LEVELS; i++) begin
      if (req[i]) begin
        lvl = 5'(i);
      end
    end
    return lvl;
  endfunction

  // Trap bit i belongs to mode 3-i; mode code 0 is the most privileged
  // A trap fires in its own mode and in every more privileged one
  function automatic logic [TRAP_W-1:0] cirsl_trap_ok(input logic [MODE_W-1:0] mode);
    logic [TRAP_W-1:0] ok;
    ok = '0;
    for (int i = 0; i < TRAP_W; i++) begin
      ok[i] = ({1'b0, mode} <= 3'(TRAP_W - 1 - i));
    end
    return ok;
  endfunction

  // Synchroniser stages for pins from outside the clock domain
  // Only the second stage is read, so a metastable first stage never reaches logic
  localparam int unsigned SYNC_W = PIN_W + 4;
  // Serial data resets to its idle level, so releasing reset is not a transition
  localparam logic [SYNC_W-1:0] SYNC_RST = {SER_IDLE, {(SYNC_W-1){1'b0}}};
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic              data_prev;
  logic [PIN_W-1:0]  pin_s;
  logic              pwr_s;
  logic              mchk_s;
  logic              halt_s;
  logic              data_s;

  // Name the second-stage bits by pin
  assign pin_s  = sync_b[PIN_W-1:0];
  assign pwr_s  = sync_b[PIN_W];
  assign mchk_s = sync_b[PIN_W+1];
  assign halt_s = sync_b[PIN_W+2];
  assign data_s = sync_b[PIN_W+3];

  // Two flops per pin, then a delayed copy of the data pin for edges
  // The delayed copy lags by one edge, so each transition shows for one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a    <= SYNC_RST;
      sync_b    <= SYNC_RST;
      data_prev <= SER_IDLE;
    end else begin
      sync_a    <= {srom_data_pin, halt_pin, machine_check_pin, power_fail_pin, irq_pin};
      sync_b    <= sync_a;
      data_prev <= data_s;
    end
  end

  // Software state
  // Written only from the register port
  logic [4:0]        threshold;
  logic [TRAP_W-1:0] trap_request;
  logic [TRAP_W-1:0] trap_enable;
  logic [SOFT_W-1:0] soft_request;
  logic [PIN_W-1:0]  external_pin_mask;
  logic              corrected_error_interrupt_enable;
  logic              serial_interrupt_enable;
  logic [MODE_W-1:0] current_mode_field;
  logic              transmit_bit;

  // Latched edge requests
  logic [CTR_W-1:0]  counter_pending;
  logic              corrected_read_pending;
  logic              serial_line_pending;

  logic [4:0]        next_threshold;
  logic [TRAP_W-1:0] next_trap_request;
  logic [TRAP_W-1:0] next_trap_enable;
  logic [SOFT_W-1:0] next_soft_request;
  logic [PIN_W-1:0]  next_external_pin_mask;
  logic              next_corrected_error_interrupt_enable;
  logic              next_serial_interrupt_enable;
  logic [MODE_W-1:0] next_current_mode_field;
  logic              next_transmit_bit;

  // Next values of the latched requests
  logic [CTR_W-1:0]  next_counter_pending;
  logic              next_corrected_read_pending;
  logic              next_serial_line_pending;
  logic              data_edge;
  logic              clr_wr;

  // Either edge of the synced data line is one transition
  assign data_edge = data_s ^ data_prev;
  assign clr_wr    = reg_we && (reg_addr == REG_CLEAR);

  // Register writes from the register port
  always_comb begin
    next_threshold                        = threshold;
    next_trap_request                     = trap_request;
    next_trap_enable                      = trap_enable;
    next_soft_request                     = soft_request;
    next_external_pin_mask                = external_pin_mask;
    next_corrected_error_interrupt_enable = corrected_error_interrupt_enable;
    next_serial_interrupt_enable          = serial_interrupt_enable;
    next_current_mode_field               = current_mode_field;
    next_transmit_bit                     = transmit_bit;
    if (reg_we) begin
      unique case (reg_addr)
        REG_THRESHOLD: next_threshold = reg_wdata[THR_LSB +: LEVEL_W];
        REG_TRAP_REQ:  next_trap_request = reg_wdata[TRAP_LSB +: TRAP_W];
        REG_TRAP_EN:   next_trap_enable = reg_wdata[TRAP_LSB +: TRAP_W];
        REG_SOFT_REQ:  next_soft_request = reg_wdata[SOFT_LSB +: SOFT_W];
        REG_CTRL_STAT: begin
          next_external_pin_mask                = reg_wdata[MASK_LSB +: PIN_W];
          next_corrected_error_interrupt_enable = reg_wdata[CRD_BIT];
          next_serial_interrupt_enable          = reg_wdata[SER_BIT];
        end
        REG_CUR_MODE:  next_current_mode_field = reg_wdata[MODE_LSB +: MODE_W];
        REG_SER_XMIT:  next_transmit_bit = reg_wdata[XMIT_BIT];
        default: begin
        end
      endcase
    end
  end

  // Latched edge requests; a new event beats a clear in the same cycle
  // Clears act only on the bits written as one
  always_comb begin
    next_counter_pending        = counter_pending;
    next_corrected_read_pending = corrected_read_pending;
    next_serial_line_pending    = serial_line_pending;
    if (clr_wr) begin
      next_counter_pending        = counter_pending & ~reg_wdata[CTR_LSB +: CTR_W];
      next_corrected_read_pending = corrected_read_pending & ~reg_wdata[CRD_BIT];
      next_serial_line_pending    = serial_line_pending & ~reg_wdata[SER_BIT];
    end
    next_counter_pending = next_counter_pending | counter_event;
    if (corrected_read_event) begin
      next_corrected_read_pending = 1'b1;
    end
    if (data_edge && serial_interrupt_enable) begin
      next_serial_line_pending = 1'b1;
    end
  end

  // Register the software state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      threshold                        <= THR_RST;
      trap_request                     <= '0;
      trap_enable                      <= '0;
      soft_request                     <= '0;
      external_pin_mask                <= '0;
      corrected_error_interrupt_enable <= 1'b0;
      serial_interrupt_enable          <= 1'b0;
      current_mode_field               <= MODE_RST;
      transmit_bit                     <= XMIT_RST;
    end else begin
      threshold                        <= next_threshold;
      trap_request                     <= next_trap_request;
      trap_enable                      <= next_trap_enable;
      soft_request                     <= next_soft_request;
      external_pin_mask                <= next_external_pin_mask;
      corrected_error_interrupt_enable <= next_corrected_error_interrupt_enable;
      serial_interrupt_enable          <= next_serial_interrupt_enable;
      current_mode_field               <= next_current_mode_field;
      transmit_bit                     <= next_transmit_bit;
    end
  end

  // Register the latched requests; they reset to nothing pending
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      counter_pending        <= '0;
      corrected_read_pending <= 1'b0;
      serial_line_pending    <= 1'b0;
    end else begin
      counter_pending        <= next_counter_pending;
      corrected_read_pending <= next_corrected_read_pending;
      serial_line_pending    <= next_serial_line_pending;
    end
  end

  // Pending summary and level request vector
  // The summary shows masked pins and disabled corrected errors too; trap enables gate bits 3:0, serial enable gates latching
  logic [TRAP_W-1:0]     trap_armed;
  logic [TRAP_W-1:0]     trap_active;
  logic [DATA_W-1:0]     summary;
  logic [NUM_LEVELS-1:0] level_req;
  logic [4:0]            top_level;

  // Trap lines armed by their enables, and those the current mode lets through
  assign trap_armed  = trap_request & trap_enable;
  assign trap_active = trap_armed & cirsl_trap_ok(current_mode_field);

  // Summary bits, one per request source
  always_comb begin
    summary = '0;
    summary[TRAP_LSB +: TRAP_W] = trap_armed;
    summary[SOFT_LSB +: SOFT_W] = soft_request;
    summary[SUM_TRAP]           = |trap_active;
    summary[SUM_PIN_LSB +: PIN_W] = pin_s;
    summary[CTR_LSB +: CTR_W]   = counter_pending;
    summary[SUM_PWR]            = pwr_s;
    summary[SUM_MCHK]           = mchk_s;
    summary[CRD_BIT]            = corrected_read_pending;
    summary[SER_BIT]            = serial_line_pending;
    summary[SUM_HALT]           = halt_s;
  end

  // One request bit per target level; masked pins drop out here only
  // All trap modes share one level, set by parameter
  always_comb begin
    level_req = '0;
    level_req[SOFT_W:1] = soft_request;
    if (|trap_active) begin
      level_req[LVL_TRAP] = 1'b1;
    end
    for (int i = 0; i < PIN_W; i++) begin
      if (pin_s[i] && !external_pin_mask[i]) begin
        level_req[LVL_PIN0 + 5'(i)] = 1'b1;
      end
    end
    if (serial_line_pending) begin
      level_req[LVL_SER] = 1'b1;
    end
    if (|counter_pending) begin
      level_req[LVL_CTR] = 1'b1;
    end
    if (pwr_s) begin
      level_req[LVL_PWR] = 1'b1;
    end
    if (mchk_s) begin
      level_req[LVL_MCHK] = 1'b1;
    end
    if (corrected_read_pending && corrected_error_interrupt_enable) begin
      level_req[LVL_CRD] = 1'b1;
    end
  end

  // Halt stays out of the level vector
  // Service code finds halt through summary bit 34, not the identifier
  assign top_level = cirsl_top_level(level_req);

  // Registered level identifier and take decision
  // A level request that drops before service lets take fall again
  logic [4:0] next_pending_level_identifier;
  logic       next_interrupt_take;
  logic       next_halt_pending;

  // Halt raises take as well, since it has no level to compare
  always_comb begin
    next_pending_level_identifier = top_level;
    next_interrupt_take           = (top_level > threshold) || halt_s;
    next_halt_pending             = halt_s;
  end

  // Outputs change one edge after the state they report
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending_level_identifier <= '0;
      interrupt_take           <= 1'b0;
      halt_pending             <= 1'b0;
    end else begin
      pending_level_identifier <= next_pending_level_identifier;
      interrupt_take           <= next_interrupt_take;
      halt_pending             <= next_halt_pending;
    end
  end

  // Shared clock pin: ROM loader owns it while active outside debug
  // Kept combinational: the loader's clock must reach the pin without delay
  always_comb begin
    if (rom_load_active && !debug_mode) begin
      srom_clk_pin = rom_load_clk;
    end else begin
      srom_clk_pin = transmit_bit;
    end
  end

  // Read data, valid the cycle after the read strobe
  // Write-only and unused indices read as zero
  logic [DATA_W-1:0] next_reg_rdata;

  always_comb begin
    next_reg_rdata = '0;
    if (reg_re) begin
      unique case (reg_addr)
        REG_THRESHOLD: next_reg_rdata[THR_LSB +: LEVEL_W] = threshold;
        REG_TRAP_REQ:  next_reg_rdata[TRAP_LSB +: TRAP_W] = trap_request;
        REG_TRAP_EN:   next_reg_rdata[TRAP_LSB +: TRAP_W] = trap_enable;
        REG_SOFT_REQ:  next_reg_rdata[SOFT_LSB +: SOFT_W] = soft_request;
        REG_SUMMARY:   next_reg_rdata = summary;
        REG_SER_RCV:   next_reg_rdata[RCV_BIT] = data_s;
        REG_CTRL_STAT: begin
          next_reg_rdata[MASK_LSB +: PIN_W] = external_pin_mask;
          next_reg_rdata[CRD_BIT]           = corrected_error_interrupt_enable;
          next_reg_rdata[SER_BIT]           = serial_interrupt_enable;
        end
        REG_CUR_MODE:  next_reg_rdata[MODE_LSB +: MODE_W] = current_mode_field;
        REG_LEVEL_ID:  next_reg_rdata[LEVEL_W-1:0] = top_level;
        default: begin
        end
      endcase
    end
  end

  // Read data register, zero whenever no read was made
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule // cirsl_top

//--- verif/cirsl_sys_model.sv
// System-side model: external request pins and serial data line
module cirsl_sys_model (
  input  wire logic       clk,
  output logic      [3:0] irq_pin,
  output logic            power_fail_pin,
  output logic            machine_check_pin,
  output logic            halt_pin,
  output logic            srom_data_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins start quiet, serial line idles high
  initial begin
    {irq_pin, power_fail_pin, machine_check_pin, halt_pin} = '0;
    srom_data_pin = 1'b1;
  end

  // Levels change just after an edge and hold; bit timing is the caller's wait loop
  task automatic drive(input logic [7:0] v);
    @(posedge clk);
    {irq_pin, power_fail_pin, machine_check_pin, halt_pin, srom_data_pin} <= v;
  endtask
endmodule : cirsl_sys_model

//--- verif/cirsl_top_properties.sv
// Checker: port-level timing of interrupt outputs and serial clock pin
module cirsl_top_properties
  import cirsl_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_we,
  input wire logic              power_fail_pin,
  input wire logic              machine_check_pin,
  input wire logic              halt_pin,
  input wire logic [CTR_W-1:0]  counter_event,
  input wire logic              rom_load_active,
  input wire logic              rom_load_clk,
  input wire logic              debug_mode,
  input wire logic              srom_clk_pin,
  input wire logic [4:0]        pending_level_identifier,
  input wire logic              interrupt_take,
  input wire logic              halt_pending
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Pin paths: two sync stages plus one output register
  halt_sync_a: assert property ($stable(halt_pin)[*3] |=> halt_pending == $past(halt_pin))
    else $error("halt pending does not follow halt pin");
  halt_take_a: assert property (halt_pending |-> interrupt_take)
    else $error("halt without interrupt take");
  take_level_a: assert property (interrupt_take && !halt_pending |->
    pending_level_identifier != 5'h00)
    else $error("interrupt taken at level zero");
  mchk_level_a: assert property ($stable(machine_check_pin)[*3] && machine_check_pin
    |=> pending_level_identifier == LVL_MCHK)
    else $error("machine check level wrong");
  pwr_level_a: assert property ($stable(power_fail_pin)[*3] && power_fail_pin
    |=> pending_level_identifier >= LVL_PWR)
    else $error("power fail level too low");
  ctr_level_a: assert property (|counter_event |-> ##2 pending_level_identifier >= LVL_CTR)
    else $error("counter request level too low");

  // Serial clock pin source selection
  xmit_pin_a: assert property (reg_we && reg_addr == REG_SER_XMIT ##1 debug_mode
    |-> srom_clk_pin == $past(reg_wdata[XMIT_BIT]))
    else $error("transmit bit not on clock pin");
  rom_mux_a: assert property (rom_load_active && !debug_mode |->
    srom_clk_pin == rom_load_clk)
    else $error("rom loader does not own clock pin");
endmodule : cirsl_top_properties

bind cirsl_top cirsl_top_properties i_cirsl_top_properties (.clk, .rst, .reg_addr, .reg_wdata,
  .reg_we, .power_fail_pin, .machine_check_pin, .halt_pin, .counter_event, .rom_load_active,
  .rom_load_clk, .debug_mode, .srom_clk_pin, .pending_level_identifier, .interrupt_take,
  .halt_pending);

//--- verif/cirsl_top_tb_top.sv
// Testbench: random register and pin traffic compared with a behavioural model
module cirsl_top_tb_top
  import cirsl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        reg_we = 1'b0;
  logic        reg_re = 1'b0;
  logic [3:0]  reg_addr = '0;
  logic [63:0] reg_wdata = '0;
  logic [63:0] reg_rdata;
  logic [2:0]  counter_event = '0;
  logic        corrected_read_event = 1'b0;
  logic        rom_load_active = 1'b0;
  logic        rom_load_clk = 1'b0;
  logic        debug_mode = 1'b0;
  logic [3:0]  irq_pin;
  logic        power_fail_pin, machine_check_pin, halt_pin, srom_data_pin;
  logic        srom_clk_pin, interrupt_take, halt_pending, old;
  logic [4:0]  pending_level_identifier;
  logic [31:0] seed = 32'h98f6_e5e1;
  logic [31:0] r;
  logic [63:0] q, s, d, e;
  logic [3:0]  a;
  int          mismatches = 0;
  int          num_checks = 0;
  int          cyc = 0;
  // Model state: stored registers, latched requests, transmit bit
  logic [63:0] m_reg [16] = '{default: '0};
  logic [63:0] msk [16] = '{0: 64'h1f, 1: 64'hf, 2: 64'hf, 3: 64'h7_fff0,
                            8: 64'h3_00f0_0000, 9: 64'h18, default: '0};
  logic [3:0]  wa [11] = '{REG_THRESHOLD, REG_TRAP_REQ, REG_TRAP_EN, REG_SOFT_REQ, REG_CLEAR,
                           REG_SUMMARY, REG_SER_XMIT, REG_CTRL_STAT, REG_CUR_MODE, 4'hb,
                           REG_LEVEL_ID};
  logic [2:0]  m_ctr = '0;
  logic        m_crd = 1'b0;
  logic        m_ser = 1'b0;
  logic        m_xmit = 1'b1;

  cirsl_top i_cirsl_top (.clk, .rst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
    .irq_pin, .power_fail_pin, .machine_check_pin, .halt_pin, .counter_event,
    .corrected_read_event, .srom_data_pin, .rom_load_active, .rom_load_clk, .debug_mode,
    .srom_clk_pin, .pending_level_identifier, .interrupt_take, .halt_pending);
  cirsl_sys_model i_cirsl_sys_model (.clk, .irq_pin, .power_fail_pin, .machine_check_pin,
    .halt_pin, .srom_data_pin);

  // Clock and hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected summary from model state and pin levels
  function automatic logic [63:0] exp_sum();
    logic [63:0] t = '0;
    t[3:0] = m_reg[1][3:0] & m_reg[2][3:0];
    for (int i = 0; i < 4; i++) if (t[i] && m_reg[9][4:3] <= 2'(3 - i)) t[19] = 1'b1;
    t[18:4] = m_reg[3][18:4];
    t[23:20] = irq_pin;
    t[34:27] = {halt_pin, m_ser, m_crd, machine_check_pin, power_fail_pin, m_ctr};
    return t;
  endfunction

  // Expected highest level, halt excluded
  function automatic logic [4:0] exp_lvl(input logic [63:0] t);
    logic [4:0] l = '0;
    for (int i = 1; i < 16; i++) if (t[i+3]) l = 5'(i);
    if (t[19] && LVL_TRAP_DEF > l) l = LVL_TRAP_DEF;
    for (int i = 0; i < 4; i++) if (t[20+i] && !m_reg[8][20+i]) l = 5'(20 + i);
    if (t[33] && LVL_SER_DEF > l) l = LVL_SER_DEF;
    if (t[29:27] != '0) l = LVL_CTR;
    if (t[30]) l = LVL_PWR;
    if (t[31] || (t[32] && m_reg[8][CRD_BIT])) l = LVL_MCHK;
    return l;
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Register port cycles
  task automatic wr(input logic [3:0] ad, input logic [63:0] dt);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= dt;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] ad, output logic [63:0] dt);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    dt = reg_rdata;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(REG_SUMMARY, q);
    chk(q, 64'h0);
    chk(64'(srom_clk_pin), 64'h1);
    $display("reset test done");
    for (int n = 0; n < 300; n++) begin
      r = xs();
      a = wa[r[31:28] % 11];
      d = {xs(), xs()};
      wr(a, d);
      if (a == REG_CLEAR) begin
        m_ctr &= ~d[29:27];
        m_crd &= ~d[CRD_BIT];
        m_ser &= ~d[SER_BIT];
      end else if (a == REG_SER_XMIT) m_xmit = d[XMIT_BIT];
      else if (a < 4'h4 || a == REG_CTRL_STAT || a == REG_CUR_MODE) m_reg[a] = d & msk[a];
      old = srom_data_pin;
      i_cirsl_sys_model.drive({r[7:4] & r[27:24], &r[10:8], &r[13:11], r[14], r[15]});
      m_ser |= (old != r[15]) && m_reg[8][SER_BIT];
      counter_event <= r[18:16];
      corrected_read_event <= r[19];
      {rom_load_active, rom_load_clk, debug_mode} <= r[22:20];
      m_ctr |= r[18:16];
      m_crd |= r[19];
      @(posedge clk);
      counter_event <= '0;
      corrected_read_event <= 1'b0;
      repeat (4) @(posedge clk);
      rd(REG_SUMMARY, q);
      s = exp_sum();
      chk(q, s);
      chk(64'(pending_level_identifier), 64'(exp_lvl(s)));
      chk(64'(interrupt_take), 64'(exp_lvl(s) > m_reg[0][4:0] || halt_pin));
      chk(64'(halt_pending), 64'(halt_pin));
      e = 64'(rom_load_active && !debug_mode ? rom_load_clk : m_xmit);
      chk(64'(srom_clk_pin), e);
      rd(REG_SER_RCV, q);
      chk(q, 64'(srom_data_pin) << RCV_BIT);
      rd(a, q);
      e = a == REG_SUMMARY ? exp_sum() : a == REG_LEVEL_ID ? 64'(exp_lvl(exp_sum())) : m_reg[a];
      chk(q, e);
    end
    $display("random test done");
    end_sim();
  end
endmodule : cirsl_top_tb_top
